/* verilog/cogp_defines.vh */
`ifndef COGP_DEFINES_VH
`define COGP_DEFINES_VH

// register byte offsets on the axi4-lite bus
`define COGP_OFS_MEMIF_CTL 8'h00
`define COGP_OFS_PIN_FUNC 8'h04
`define COGP_OFS_PIN_DIR 8'h08
`define COGP_OFS_PIN_OUT 8'h0C
`define COGP_OFS_PIN_IN 8'h10
`define COGP_OFS_POLARITY 8'h14
`define COGP_OFS_IRQ_STATUS 8'h18
`define COGP_OFS_IRQ_MASK 8'h1C

// field positions
`define COGP_BIT_CLK_EN 0
`define COGP_BIT_PIN_TWO_SEL 0
`define COGP_BIT_PIN_TWO 2
`define COGP_HIGH_MSB 7
`define COGP_HIGH_LSB 4

// reset values
`define COGP_RST_CLK_EN 1'b1
`define COGP_RST_PIN_TWO_SEL 1'b0
`define COGP_RST_BYTE 8'h00
`define COGP_RST_NIBBLE 4'h0
`define COGP_RST_WORD 32'h0000_0000

// axi response codes
`define COGP_RESP_OKAY 2'b00
`define COGP_RESP_SLVERR 2'b10

`endif

/* verilog/cogp_half_rate.v */
`timescale 1ns/1ns

// internal half-rate clock: toggles on every rising core clock edge
module cogp_half_rate
(
  input wire core_clk,
  input wire reset_n,
  output reg internal_half_rate_clock
);

  // free-running divide by two, low out of reset
  always @(posedge core_clk)
  begin
    if (!reset_n)
      internal_half_rate_clock <= 1'b0;
    else
      internal_half_rate_clock <= ~internal_half_rate_clock;
  end

endmodule // cogp_half_rate

/* verilog/cogp_edge_detect.v */
`timescale 1ns/1ns

// synchroniser and selectable edge detector for one interrupt line
module cogp_edge_detect
(
  input wire core_clk,
  input wire reset_n,
  input wire pin_level,
  input wire falling_sel,
  output reg edge_pulse
);

  reg sync_first; // first stage, read only by sync_second
  reg sync_second; // stable copy of the pin
  reg level_prev; // previous stable level

  // two-flop synchroniser, history flop and one-cycle event
  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
      level_prev <= 1'b0;
      edge_pulse <= 1'b0;
    end
    else
    begin
      sync_first <= pin_level;
      sync_second <= sync_first;
      level_prev <= sync_second;
      // falling_sel low picks rising edges, high picks falling edges
      if (falling_sel)
        edge_pulse <= level_prev & ~sync_second;
      else
        edge_pulse <= ~level_prev & sync_second;
    end
  end

endmodule // cogp_edge_detect

/* verilog/cogp_gpio_top.v */
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "cogp_defines.vh"

// Functional notes
// - shared pin outputs half-rate clock after reset
// - software can make shared pin general pin two
// - clock enable bit gates clock, resets one
// - pins seven to four: gpio plus edge interrupts
// - four polarity bits pick each active edge
module cogp_gpio_top
(
  input wire core_clk,
  input wire reset_n,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // shared pin: half-rate clock or general pin two
  input wire general_pin_two_in,
  output reg general_pin_two_out,
  output reg general_pin_two_oe,
  // general pins seven..four, bit 3 is pin seven
  input wire [3:0] general_pins_high_in,
  output reg [3:0] general_pins_high_out,
  output reg [3:0] general_pins_high_oe,
  // level interrupt to the processor
  output reg ext_irq_out
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  reg half_rate_clock_out_enable; // memif global control bit
  reg pin_two_gpio_sel; // 0 clock, 1 general pin two
  reg [7:0] pin_dir; // 1 drives the pin
  reg [7:0] pin_out_val; // value driven when enabled
  reg [3:0] ext_irq_edge_polarity; // 0 rising, 1 falling
  reg [3:0] irq_status; // sticky edge events
  reg [3:0] irq_mask; // 1 lets a status bit interrupt

  // write channel state
  reg aw_full; // write address held
  reg [7:0] aw_addr_q; // held write address
  reg w_full; // write data held
  reg [31:0] w_data_q; // held write data
  reg [3:0] w_strb_q; // held byte enables

  wire internal_half_rate_clock; // divider output
  wire [3:0] edge_event; // one-cycle edge pulses
  wire aw_take; // write address handshake
  wire w_take; // write data handshake
  wire wr_commit; // both halves held, perform the write
  wire wr_low_byte; // low lane enabled in held write
  wire ar_take; // read address handshake
  wire [3:0] status_w1c; // bits written one to status
  reg [31:0] rd_word; // read mux output
  reg [3:0] next_irq_status; // status after set and clear

  // true for every mapped offset
  function addr_known;
    input [7:0] a;
    begin
      addr_known = (a == `COGP_OFS_MEMIF_CTL) || (a == `COGP_OFS_PIN_FUNC) ||
                   (a == `COGP_OFS_PIN_DIR) || (a == `COGP_OFS_PIN_OUT) ||
                   (a == `COGP_OFS_PIN_IN) || (a == `COGP_OFS_POLARITY) ||
                   (a == `COGP_OFS_IRQ_STATUS) || (a == `COGP_OFS_IRQ_MASK);
    end
  endfunction

  // ---------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------

  // half-rate clock source for the shared pin
  cogp_half_rate u_half_rate
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .internal_half_rate_clock(internal_half_rate_clock)
  );

  // one edge detector per interrupt pin, pin four first
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_edge
      cogp_edge_detect u_edge
      (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_level(general_pins_high_in[gi]),
        .falling_sel(ext_irq_edge_polarity[gi]),
        .edge_pulse(edge_event[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // axi write path
  // ---------------------------------------------------------------
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_commit = aw_full & w_full & ~s_axi_bvalid;
  assign wr_low_byte = w_strb_q[0];
  assign status_w1c = (wr_commit && wr_low_byte && aw_addr_q == `COGP_OFS_IRQ_STATUS) ?
                      w_data_q[3:0] : `COGP_RST_NIBBLE;

  // address and data captured in either order, answered once both held
  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `COGP_RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_q <= `COGP_RST_BYTE;
      w_data_q <= `COGP_RST_WORD;
      w_strb_q <= `COGP_RST_NIBBLE;
    end
    else
    begin
      // hold the address until the response is accepted
      if (aw_take)
      begin
        aw_full <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      // hold the data likewise
      if (w_take)
      begin
        w_full <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // raise the response the cycle after both are held
      if (wr_commit)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(aw_addr_q) ? `COGP_RESP_OKAY : `COGP_RESP_SLVERR;
      end
      // response taken: reopen both channels
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // software-written control registers
  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      half_rate_clock_out_enable <= `COGP_RST_CLK_EN;
      pin_two_gpio_sel <= `COGP_RST_PIN_TWO_SEL;
      pin_dir <= `COGP_RST_BYTE;
      pin_out_val <= `COGP_RST_BYTE;
      ext_irq_edge_polarity <= `COGP_RST_NIBBLE;
      irq_mask <= `COGP_RST_NIBBLE;
    end
    else if (wr_commit && wr_low_byte)
    begin
      case (aw_addr_q)
        `COGP_OFS_MEMIF_CTL:
          half_rate_clock_out_enable <= w_data_q[`COGP_BIT_CLK_EN];
        `COGP_OFS_PIN_FUNC:
          pin_two_gpio_sel <= w_data_q[`COGP_BIT_PIN_TWO_SEL];
        `COGP_OFS_PIN_DIR:
          pin_dir <= w_data_q[7:0];
        `COGP_OFS_PIN_OUT:
          pin_out_val <= w_data_q[7:0];
        `COGP_OFS_POLARITY:
          ext_irq_edge_polarity <= w_data_q[3:0];
        `COGP_OFS_IRQ_MASK:
          irq_mask <= w_data_q[3:0];
        default:
          pin_dir <= pin_dir; // status, input and unmapped: no store
      endcase
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, mask and output
  // ---------------------------------------------------------------

  // a new edge wins over a write-one clear in the same cycle
  always @*
  begin
    next_irq_status = (irq_status & ~status_w1c) | edge_event;
  end

  // sticky status and registered level interrupt
  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      irq_status <= `COGP_RST_NIBBLE;
      ext_irq_out <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      ext_irq_out <= |(next_irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // axi read path
  // ---------------------------------------------------------------
  assign ar_take = s_axi_arvalid & s_axi_arready;

  // read mux, unused bits read as zero
  always @*
  begin
    rd_word = `COGP_RST_WORD;
    case (s_axi_araddr)
      `COGP_OFS_MEMIF_CTL:
        rd_word[`COGP_BIT_CLK_EN] = half_rate_clock_out_enable;
      `COGP_OFS_PIN_FUNC:
        rd_word[`COGP_BIT_PIN_TWO_SEL] = pin_two_gpio_sel;
      `COGP_OFS_PIN_DIR:
        rd_word[7:0] = pin_dir;
      `COGP_OFS_PIN_OUT:
        rd_word[7:0] = pin_out_val;
      `COGP_OFS_PIN_IN:
      begin
        // live pin levels; pin two reads back even in clock mode
        rd_word[`COGP_BIT_PIN_TWO] = general_pin_two_in;
        rd_word[`COGP_HIGH_MSB:`COGP_HIGH_LSB] = general_pins_high_in;
      end
      `COGP_OFS_POLARITY:
        rd_word[3:0] = ext_irq_edge_polarity;
      `COGP_OFS_IRQ_STATUS:
        rd_word[3:0] = irq_status;
      `COGP_OFS_IRQ_MASK:
        rd_word[3:0] = irq_mask;
      default:
        rd_word = `COGP_RST_WORD;
    endcase
  end

  // one read at a time, data the cycle after the address is taken
  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `COGP_RST_WORD;
      s_axi_rresp <= `COGP_RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= addr_known(s_axi_araddr) ? `COGP_RESP_OKAY : `COGP_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------

  // shared pin: clock role by default, gpio role when selected
  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      general_pin_two_out <= 1'b0;
      general_pin_two_oe <= 1'b0;
    end
    else if (!pin_two_gpio_sel)
    begin
      // clock role: enable bit drives or stops the clock
      general_pin_two_out <= internal_half_rate_clock & half_rate_clock_out_enable;
      general_pin_two_oe <= half_rate_clock_out_enable;
    end
    else
    begin
      // gpio role: input, output or high impedance
      general_pin_two_out <= pin_out_val[`COGP_BIT_PIN_TWO];
      general_pin_two_oe <= pin_dir[`COGP_BIT_PIN_TWO];
    end
  end

  // pins seven..four as plain gpio outputs
  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      general_pins_high_out <= `COGP_RST_NIBBLE;
      general_pins_high_oe <= `COGP_RST_NIBBLE;
    end
    else
    begin
      general_pins_high_out <= pin_out_val[`COGP_HIGH_MSB:`COGP_HIGH_LSB];
      general_pins_high_oe <= pin_dir[`COGP_HIGH_MSB:`COGP_HIGH_LSB];
    end
  end

endmodule // cogp_gpio_top

/* verification/cogp_gpio_assertions.sv */
`timescale 1ns/1ns

// port-level checks beside the gpio top
module cogp_gpio_assertions
(
  input wire core_clk,
  input wire reset_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] general_pins_high_in,
  input wire general_pin_two_oe,
  input wire ext_irq_out
);
  // one clock domain, one reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_clk_after_rst: assert property ($rose(reset_n) |=> general_pin_two_oe)
    else $error("shared pin not driven after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  a_irq_cause: assert property ($rose(ext_irq_out) |-> s_axi_bvalid
    || $past(s_axi_bvalid) || $past(general_pins_high_in, 4)
    != $past(general_pins_high_in, 5))
    else $error("interrupt without cause");
  a_irq_drop: assert property ($fell(ext_irq_out) |-> s_axi_bvalid
    || $past(s_axi_bvalid))
    else $error("interrupt dropped without write");
endmodule // cogp_gpio_assertions

/* verification/cogp_board_model.sv */
`timescale 1ns/1ns

// board side: optional drivers, else pull resistors
module cogp_board_model
(
  input wire two_out,
  input wire two_oe,
  input wire [3:0] high_out,
  input wire [3:0] high_oe,
  input wire [4:0] drv_en,
  input wire [4:0] drv_val,
  output wire two_pin,
  output wire [3:0] high_pin
);
  // shared pin: device, board, else pull-down
  assign two_pin = two_oe ? two_out : (drv_en[4] & drv_val[4]);
  // pins seven..four: device, board, else pull-up
  assign high_pin = (high_oe & high_out) | (~high_oe & ~drv_en[3:0])
    | (~high_oe & drv_en[3:0] & drv_val[3:0]);
endmodule // cogp_board_model

/* verification/testbench.sv */
`timescale 1ns/1ns
`include "cogp_defines.vh"

// register, pin and interrupt tests
module testbench;
  // table row: address, reset value, write, readback, response
  typedef struct {logic [7:0] a; logic [31:0] rst, wd, rb; logic [1:0] r;} cogp_row_t;
  reg core_clk = 0;
  reg reset_n = 0;
  reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire general_pin_two_in, general_pin_two_out, general_pin_two_oe, ext_irq_out;
  wire [3:0] general_pins_high_in, general_pins_high_out, general_pins_high_oe;
  reg [4:0] drv_en = 0, drv_val = 0;
  integer n_fail = 0, comparisons = 0, i;
  reg t;
  cogp_row_t rows[7] = '{
    '{`COGP_OFS_MEMIF_CTL, 32'h1, 32'h0, 32'h0, `COGP_RESP_OKAY},
    '{`COGP_OFS_PIN_FUNC, 32'h0, 32'h1, 32'h1, `COGP_RESP_OKAY},
    '{`COGP_OFS_PIN_DIR, 32'h0, 32'hF4, 32'hF4, `COGP_RESP_OKAY},
    '{`COGP_OFS_PIN_OUT, 32'h0, 32'hA4, 32'hA4, `COGP_RESP_OKAY},
    '{`COGP_OFS_POLARITY, 32'h0, 32'h5, 32'h5, `COGP_RESP_OKAY},
    '{`COGP_OFS_IRQ_MASK, 32'h0, 32'h3, 32'h3, `COGP_RESP_OKAY},
    '{8'h20, 32'h0, 32'hFF, 32'h0, `COGP_RESP_SLVERR}};

  // core clock, 8 ns period
  always #4 core_clk = ~core_clk;

  cogp_gpio_top u_dut (.*);

  // board pins and pulls
  cogp_board_model u_board (.two_out(general_pin_two_out), .two_oe(general_pin_two_oe),
    .high_out(general_pins_high_out), .high_oe(general_pins_high_oe), .drv_en(drv_en),
    .drv_val(drv_val), .two_pin(general_pin_two_in), .high_pin(general_pins_high_in));

  // compare one value
  task chk(input string n, input [31:0] e, input [31:0] s);
    begin
      comparisons++;
      if (s !== e)
      begin
        $display("Error %s expected %h seen %h", n, e, s);
        n_fail++;
      end
    end
  endtask

  // axi4-lite write, response checked
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    integer n;
    begin
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (n = 0; n < 50; n++)
      begin
        @(posedge core_clk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        if (s_axi_bvalid) break;
      end
      chk("bresp", r, s_axi_bresp);
      s_axi_bready <= 0;
    end
  endtask

  // axi4-lite read, data and response checked
  task rd(input [7:0] a, input [31:0] d, input [1:0] r);
    integer n;
    begin
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (n = 0; n < 50; n++)
      begin
        @(posedge core_clk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        if (s_axi_rvalid) break;
      end
      chk("rdata", d, s_axi_rdata);
      chk("rresp", r, s_axi_rresp);
      s_axi_rready <= 0;
    end
  endtask

  // counts and verdict
  task end_sim;
    begin
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    end_sim;
  end

  // main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1;
    repeat (2) @(posedge core_clk);
    chk("oe2", 1, general_pin_two_oe);
    chk("oeh", 0, general_pins_high_oe);
    t = general_pin_two_out;
    @(posedge core_clk);
    chk("tog", !t, general_pin_two_out);
    for (i = 0; i < 7; i++)
    begin
      rd(rows[i].a, rows[i].rst, rows[i].r);
      wr(rows[i].a, rows[i].wd, rows[i].r);
      rd(rows[i].a, rows[i].rb, rows[i].r);
    end
    repeat (2) @(posedge core_clk);
    chk("out2", 1, general_pin_two_out);
    chk("oe2", 1, general_pin_two_oe);
    chk("outh", 4'hA, general_pins_high_out);
    chk("oeh", 4'hF, general_pins_high_oe);
    // clock role, enable off then on
    wr(`COGP_OFS_PIN_FUNC, 0, `COGP_RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk("oe2", 0, general_pin_two_oe);
    chk("out2", 0, general_pin_two_out);
    wr(`COGP_OFS_MEMIF_CTL, 1, `COGP_RESP_OKAY);
    repeat (2) @(posedge core_clk);
    t = general_pin_two_out;
    @(posedge core_clk);
    chk("tog", !t, general_pin_two_out);
    // release pins to the board, clear status
    drv_en <= 5'h0F;
    drv_val <= 5'h0F;
    wr(`COGP_OFS_PIN_DIR, 0, `COGP_RESP_OKAY);
    repeat (8) @(posedge core_clk);
    wr(`COGP_OFS_IRQ_STATUS, 32'hF, `COGP_RESP_OKAY);
    rd(`COGP_OFS_IRQ_STATUS, 0, `COGP_RESP_OKAY);
    // falling edges fire lines four and six only
    drv_val <= 5'h00;
    repeat (8) @(posedge core_clk);
    rd(`COGP_OFS_IRQ_STATUS, 32'h5, `COGP_RESP_OKAY);
    chk("irq", 1, ext_irq_out);
    wr(`COGP_OFS_IRQ_MASK, 0, `COGP_RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk("irq", 0, ext_irq_out);
    // rising edges fire lines five and seven
    drv_val <= 5'h0F;
    repeat (8) @(posedge core_clk);
    wr(`COGP_OFS_IRQ_STATUS, 32'h5, `COGP_RESP_OKAY);
    rd(`COGP_OFS_IRQ_STATUS, 32'hA, `COGP_RESP_OKAY);
    // second reset restores defaults
    reset_n <= 0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1;
    rd(`COGP_OFS_MEMIF_CTL, 1, `COGP_RESP_OKAY);
    rd(`COGP_OFS_PIN_FUNC, 0, `COGP_RESP_OKAY);
    chk("oe2", 1, general_pin_two_oe);
    end_sim;
  end
endmodule // testbench

bind cogp_gpio_top cogp_gpio_assertions u_chk (.*);
